// ### logic/fifo_chain_defs.svh
/*
  Constants for the FIFO-chain controller: register offsets, field positions,
  reset values and pin timing counts at a 20 MHz clock.
  Assumes the includer is a module on the single 20 MHz clock.
*/
// Behaviour
// - Expansion input pulses must precede the strobes they enable.
// - Strobe, reset, retransmit and expansion pulses must meet minimum widths.
// - Each system watches full of the device it writes, empty of the one it reads; the controller flags empty or full when any device does.
// - Depth and width expansion may be combined, also in paired buffers.
// - Chain each expansion output to the next input; first-load high except first.
// - Retransmit is never used in depth expansion mode.
`ifndef FIFO_CHAIN_DEFS_SVH
`define FIFO_CHAIN_DEFS_SVH

// Register offsets.
`define REG_CONTROL 8'h00
`define REG_WRDATA 8'h04
`define REG_RDDATA 8'h08
`define REG_STATUS 8'h0C
`define REG_IRQ_STATUS 8'h10
`define REG_IRQ_ENABLE 8'h14
`define REG_IRQ_CLEAR 8'h18
`define REG_COUNT 8'h1C

// Control register fields.
`define CTL_RESET_BIT 0
`define CTL_RETX_BIT 1
`define CTL_DEPTH_BIT 2
`define CTL_READ_BIT 3
`define CTL_RESET_VALUE 3'h4

// Status and interrupt fields.
`define ST_EMPTY_BIT 0
`define ST_FULL_BIT 1
`define ST_BUSY_BIT 2
`define IRQ_WRDONE_BIT 0
`define IRQ_RDDONE_BIT 1
`define IRQ_REFUSED_BIT 2
`define IRQ_BITS 3

// Timing: slowest grade figures in ns, counts rounded up at 50 ns.
`define CLK_PERIOD_NS 50
`define T_STROBE_NS 200
`define T_RECOVER_NS 35
`define T_RESET_SETUP_NS 180
`define T_ACCESS_NS 200
`define CYCLES_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define N_STROBE `CYCLES_UP(`T_STROBE_NS)
`define N_RECOVER `CYCLES_UP(`T_RECOVER_NS)
`define N_RESET_SETUP `CYCLES_UP(`T_RESET_SETUP_NS)
`define N_ACCESS `CYCLES_UP(`T_ACCESS_NS)

`endif

// ### logic/fifo_chain_pkg.sv
/*
  Types for the FIFO-chain controller.
  Assumes nothing of its surroundings.
*/
package fifo_chain_pkg;
  typedef enum logic [2:0] {IDLE, RS_HOLD, RS_REC, WR_LOW, RD_LOW, RT_LOW, RECOVER} state_e;
  typedef logic [3:0] count_t;
endpackage

// ### logic/pin_sync.sv
/*
  Two-flip-flop synchroniser for a group of asynchronous pin inputs.
  Assumes the pins are stable levels relative to the clock period.
*/
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Pins and their synchronised copies.
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinSync
);
  logic [WIDTH-1:0] stage1;

  // Only the second stage reads the first one.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage1 <= INIT;
      pinSync <= INIT;
    end
    else
    begin
      stage1 <= pinIn;
      pinSync <= stage1;
    end
  end
endmodule

// ### logic/pulse_timer.sv
/*
  Down-counter that times a phase of a pin cycle in clock cycles.
  Assumes load and the count come from logic on the same clock.
*/
`timescale 1ns/1ns
module pulse_timer (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Control.
  input wire logic load,
  input wire fifo_chain_pkg::count_t loadValue,
  // Status.
  output logic done
);
  fifo_chain_pkg::count_t remaining;

  // Loads a count and runs it down to zero.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      remaining <= 4'h0;
    else if (load)
      remaining <= loadValue;
    else if (remaining != 4'h0)
      remaining <= remaining - 4'h1;
  end

  assign done = (remaining == 4'h0) && !load;
endmodule

// ### logic/fifo_chain_ctrl.sv
/*
  Controller that drives a daisy-chained set of depth-expanded FIFOs through
  their shared write, read, reset and first-load/retransmit pins, and exposes a
  small register port to software.
  Assumes the chained devices share data and strobe lines, that the chain is
  wired output to input, and that software uses one-cycle strobes.
*/
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
`include "fifo_chain_defs.svh"
module fifo_chain_ctrl #(
  parameter int DATA_WIDTH = 9,
  parameter int DEVICES = 3,
  parameter int DEPTH = 512
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Software register port.
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  output logic irq,
  // Shared strobes to the chain.
  output logic writeStrobe_n,
  output logic readStrobe_n,
  output logic fifoReset_n,
  output logic firstLoadRetx_n,
  output logic expansionIn_n,
  // Shared data lines.
  output logic [DATA_WIDTH-1:0] dataToFifo,
  input wire logic [DATA_WIDTH-1:0] dataFromFifo,
  // Per-device flags.
  input wire logic [DEVICES-1:0] emptyFlag_n,
  input wire logic [DEVICES-1:0] fullFlag_n
);
  localparam int CW = $clog2(DEPTH * DEVICES + 1);

  fifo_chain_pkg::state_e state;
  logic [DEVICES-1:0] emptySync_n;
  logic [DEVICES-1:0] fullSync_n;
  logic [DATA_WIDTH-1:0] dataSync;
  logic anyEmpty;
  logic anyFull;
  logic timerLoad;
  fifo_chain_pkg::count_t timerValue;
  logic timerDone;
  logic depthMode;
  logic [DATA_WIDTH-1:0] rdData;
  logic [CW-1:0] wordCount;
  logic [`IRQ_BITS-1:0] irqStatus;
  logic [`IRQ_BITS-1:0] irqEnable;
  logic [`IRQ_BITS-1:0] irqSet;
  logic startWrite;
  logic startRead;
  logic startReset;
  logic startRetx;
  logic refused;

  // Decodes whether a register address hits a given offset.
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
    hit = (addr == offset);
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  // Flags and read data come from the devices and are synchronised first.
  pin_sync #(.WIDTH(DEVICES), .INIT('0)) emptySyncInst (
    .clk(clk),
    .reset_n(reset_n),
    .pinIn(emptyFlag_n),
    .pinSync(emptySync_n)
  );
  pin_sync #(.WIDTH(DEVICES), .INIT('0)) fullSyncInst (
    .clk(clk),
    .reset_n(reset_n),
    .pinIn(fullFlag_n),
    .pinSync(fullSync_n)
  );
  pin_sync #(.WIDTH(DATA_WIDTH), .INIT('0)) dataSyncInst (
    .clk(clk),
    .reset_n(reset_n),
    .pinIn(dataFromFifo),
    .pinSync(dataSync)
  );

  // Composite flags: the chain is empty or full when any device says so.
  // Every device's flags are watched: a depth chain refuses reads while any device is empty and writes while any is full.
  assign anyEmpty = ~&emptySync_n;
  assign anyFull = ~&fullSync_n;

  //////////////////////////////////////////////////////////////////////////////

  // Software orders, decoded from register writes.
  assign startWrite = regWrite && hit(regAddr, `REG_WRDATA);
  assign startRead = regWrite && hit(regAddr, `REG_CONTROL) && regWdata[`CTL_READ_BIT];
  assign startReset = regWrite && hit(regAddr, `REG_CONTROL) && regWdata[`CTL_RESET_BIT];
  assign startRetx = regWrite && hit(regAddr, `REG_CONTROL) && regWdata[`CTL_RETX_BIT];
  // Orders that arrive while busy, against a full or empty chain, or a retransmit in
  // depth mode, are refused and flagged.
  assign refused = (startWrite || startRead || startReset || startRetx) &&
                   ((state != fifo_chain_pkg::IDLE) ||
                    (startWrite && anyFull) || (startRead && anyEmpty) ||
                    (startRetx && depthMode));

  pulse_timer timerInst (
    .clk(clk),
    .reset_n(reset_n),
    .load(timerLoad),
    .loadValue(timerValue),
    .done(timerDone)
  );

  //////////////////////////////////////////////////////////////////////////////

  // Pin sequencer: every pulse is held at least its minimum width and then recovers.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= fifo_chain_pkg::IDLE;
      writeStrobe_n <= 1'b1;
      readStrobe_n <= 1'b1;
      fifoReset_n <= 1'b1;
      firstLoadRetx_n <= 1'b0;
      timerLoad <= 1'b0;
      timerValue <= 4'h0;
    end
    else
    begin
      timerLoad <= 1'b0;
      case (state)
        fifo_chain_pkg::IDLE:
        begin
          if (!refused && startReset)
          begin
            fifoReset_n <= 1'b0;
            timerValue <= 4'(`N_RESET_SETUP);
            timerLoad <= 1'b1;
            state <= fifo_chain_pkg::RS_HOLD;
          end
          else if (!refused && startWrite)
          begin
            writeStrobe_n <= 1'b0;
            timerValue <= 4'(`N_STROBE);
            timerLoad <= 1'b1;
            state <= fifo_chain_pkg::WR_LOW;
          end
          else if (!refused && startRead)
          begin
            readStrobe_n <= 1'b0;
            timerValue <= 4'(`N_ACCESS);
            timerLoad <= 1'b1;
            state <= fifo_chain_pkg::RD_LOW;
          end
          else if (!refused && startRetx)
          begin
            firstLoadRetx_n <= 1'b0;
            timerValue <= 4'(`N_STROBE);
            timerLoad <= 1'b1;
            state <= fifo_chain_pkg::RT_LOW;
          end
        end
        fifo_chain_pkg::RS_HOLD:
        begin
          // First-load low marks the first device; in single mode the pin idles high.
          firstLoadRetx_n <= !depthMode;
          if (timerDone)
          begin
            fifoReset_n <= 1'b1;
            timerValue <= 4'(`N_RECOVER);
            timerLoad <= 1'b1;
            state <= fifo_chain_pkg::RECOVER;
          end
        end
        fifo_chain_pkg::WR_LOW:
          if (timerDone)
          begin
            writeStrobe_n <= 1'b1;
            timerValue <= 4'(`N_RECOVER);
            timerLoad <= 1'b1;
            state <= fifo_chain_pkg::RECOVER;
          end
        fifo_chain_pkg::RD_LOW:
          if (timerDone)
          begin
            readStrobe_n <= 1'b1;
            timerValue <= 4'(`N_RECOVER);
            timerLoad <= 1'b1;
            state <= fifo_chain_pkg::RECOVER;
          end
        fifo_chain_pkg::RT_LOW:
          if (timerDone)
          begin
            firstLoadRetx_n <= 1'b1;
            timerValue <= 4'(`N_RECOVER);
            timerLoad <= 1'b1;
            state <= fifo_chain_pkg::RECOVER;
          end
        default:
          if (timerDone)
            state <= fifo_chain_pkg::IDLE;
      endcase
    end
  end

  // The first device's expansion input is high in depth mode and low in single mode.
  // It only moves while the chain reset is low, so it is settled before any strobe.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      expansionIn_n <= 1'b1;
    else if (state == fifo_chain_pkg::RS_HOLD)
      expansionIn_n <= depthMode;
  end

  //////////////////////////////////////////////////////////////////////////////

  // Write data launches with the falling strobe and stays still under it; read data
  // is captured at the end of the read pulse.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dataToFifo <= '0;
      rdData <= '0;
    end
    else
    begin
      if (startWrite && state == fifo_chain_pkg::IDLE)
        dataToFifo <= regWdata[DATA_WIDTH-1:0];
      if (state == fifo_chain_pkg::RD_LOW && timerDone)
        rdData <= dataSync;
    end
  end

  // Word count tracks how far the chain is filled, cleared by a chain reset.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      wordCount <= '0;
    else if (state == fifo_chain_pkg::RS_HOLD)
      wordCount <= '0;
    else if (state == fifo_chain_pkg::WR_LOW && timerDone)
      wordCount <= wordCount + CW'(1);
    else if (state == fifo_chain_pkg::RD_LOW && timerDone && wordCount != '0)
      wordCount <= wordCount - CW'(1);
  end

  // Depth-mode selection from the control register.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      depthMode <= 1'b1;
    else if (regWrite && hit(regAddr, `REG_CONTROL) && state == fifo_chain_pkg::IDLE)
      depthMode <= regWdata[`CTL_DEPTH_BIT];
  end

  //////////////////////////////////////////////////////////////////////////////

  // Interrupt events: write done, read done, order refused; set wins over clear.
  assign irqSet[`IRQ_WRDONE_BIT] = (state == fifo_chain_pkg::WR_LOW) && timerDone;
  assign irqSet[`IRQ_RDDONE_BIT] = (state == fifo_chain_pkg::RD_LOW) && timerDone;
  assign irqSet[`IRQ_REFUSED_BIT] = refused;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irqStatus <= '0;
      irqEnable <= '0;
    end
    else
    begin
      if (regWrite && hit(regAddr, `REG_IRQ_ENABLE))
        irqEnable <= regWdata[`IRQ_BITS-1:0];
      if (regWrite && hit(regAddr, `REG_IRQ_CLEAR))
        irqStatus <= (irqStatus & ~regWdata[`IRQ_BITS-1:0]) | irqSet;
      else
        irqStatus <= irqStatus | irqSet;
    end
  end

  // Registered interrupt line.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      irq <= 1'b0;
    else
      irq <= |(irqStatus & irqEnable);
  end

  // Register read port, data valid one cycle after the read strobe.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      regRdata <= 32'h00000000;
    else if (!regRead)
      regRdata <= 32'h00000000;
    else if (hit(regAddr, `REG_CONTROL))
      regRdata <= {29'h0, depthMode, 2'h0};
    else if (hit(regAddr, `REG_RDDATA))
      regRdata <= 32'(rdData);
    else if (hit(regAddr, `REG_STATUS))
      regRdata <= {29'h0, state != fifo_chain_pkg::IDLE, anyFull, anyEmpty};
    else if (hit(regAddr, `REG_IRQ_STATUS))
      regRdata <= 32'(irqStatus);
    else if (hit(regAddr, `REG_IRQ_ENABLE))
      regRdata <= 32'(irqEnable);
    else if (hit(regAddr, `REG_COUNT))
      regRdata <= 32'(wordCount);
    else
      regRdata <= 32'h00000000;
  end
endmodule

// ### testbench/fifo_chain_props.sv
/*
  Pin timing checker for the FIFO-chain controller.
  Assumes it is bound onto the controller and runs on its one clock.
*/
`timescale 1ns/1ns
module fifo_chain_props #(
  parameter int DATA_WIDTH = 9
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic reset_n,
  // Chain pins.
  input wire logic writeStrobe_n,
  input wire logic readStrobe_n,
  input wire logic fifoReset_n,
  input wire logic firstLoadRetx_n,
  input wire logic expansionIn_n,
  input wire logic [DATA_WIDTH-1:0] dataToFifo
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Pulses keep their minimum width and recovery.
  wr_width_a: assert property ($fell(writeStrobe_n) |-> (!writeStrobe_n)[*4])
    else $error("write strobe too short");
  rd_width_a: assert property ($fell(readStrobe_n) |-> (!readStrobe_n)[*4])
    else $error("read strobe too short");
  rst_width_a: assert property ($fell(fifoReset_n) |-> (!fifoReset_n)[*4])
    else $error("chain reset too short");
  wr_gap_a: assert property ($rose(writeStrobe_n) |-> ##1 (writeStrobe_n && readStrobe_n))
    else $error("no recovery after write");
  rd_gap_a: assert property ($rose(readStrobe_n) |-> ##1 (writeStrobe_n && readStrobe_n))
    else $error("no recovery after read");
  // Reset, data and mode pins stay coherent.
  rst_quiet_a: assert property (!fifoReset_n |-> writeStrobe_n && readStrobe_n)
    else $error("strobe active during chain reset");
  data_hold_a: assert property (!writeStrobe_n && !$fell(writeStrobe_n) |-> $stable(dataToFifo))
    else $error("write data moved under strobe");
  retx_depth_a: assert property (expansionIn_n && fifoReset_n |-> !firstLoadRetx_n)
    else $error("retransmit in depth mode");
  // Main scenarios.
  cover property ($fell(writeStrobe_n));
  cover property ($fell(readStrobe_n));
  cover property ($fell(fifoReset_n));
  cover property ($fell(firstLoadRetx_n) && fifoReset_n);
endmodule
bind fifo_chain_ctrl fifo_chain_props #(.DATA_WIDTH(DATA_WIDTH)) i_fifo_chain_props (
  .clk(clk), .reset_n(reset_n), .writeStrobe_n(writeStrobe_n), .readStrobe_n(readStrobe_n),
  .fifoReset_n(fifoReset_n), .firstLoadRetx_n(firstLoadRetx_n),
  .expansionIn_n(expansionIn_n), .dataToFifo(dataToFifo));

// ### testbench/fifo_dev_model.sv
/*
  Behavioural model of one depth-expandable FIFO device.
  Assumes one master drives the strobes within the minimum widths.
*/
`timescale 1ns/1ns
module fifo_dev_model #(
  parameter int DATA_WIDTH = 9,
  parameter int DEPTH = 4,
  parameter int ACCESS_NS = 150
) (
  // Control pins.
  input wire logic writeStrobe_n,
  input wire logic readStrobe_n,
  input wire logic fifoReset_n,
  input wire logic firstLoadRetx_n,
  input wire logic expansionIn_n,
  // Data, flags and expansion output.
  input wire logic [DATA_WIDTH-1:0] dataIn,
  output logic [DATA_WIDTH-1:0] dataOut,
  output logic emptyFlag_n,
  output logic fullFlag_n,
  output logic expansionOut_n
);
  logic [DATA_WIDTH-1:0] mem [DEPTH];
  logic [DATA_WIDTH-1:0] word = '0;
  int wPtr = 0, rPtr = 0, fill = 0, xiCount = 0;
  logic single = 1'b0, wEn = 1'b0, rEn = 1'b0, wGo = 1'b0, rGo = 1'b0;
  logic lastW = 1'b0, lastR = 1'b0, reading = 1'b0, wDly, rDly;
  ////////////////////////////////////////////////////////////////////////////////
  // Flags follow pointer distance; released data shows the inverse word.
  assign emptyFlag_n = fill != 0;
  assign fullFlag_n = fill != DEPTH;
  assign #(ACCESS_NS) dataOut = reading ? word : ~word;
  // The expansion pulse copies its strobe, a little later.
  assign #10 wDly = writeStrobe_n;
  assign #10 rDly = readStrobe_n;
  assign expansionOut_n = !((lastW && !wDly) || (lastR && !rDly));
  // Reset returns the pointers and latches the mode pins.
  always @(negedge fifoReset_n)
  begin
    wPtr = 0;
    rPtr = 0;
    fill = 0;
    xiCount = 0;
  end
  always @(posedge fifoReset_n)
  begin
    single = !expansionIn_n;
    wEn = single || !firstLoadRetx_n;
    rEn = wEn;
  end
  // Retransmit rewinds the read pointer to the first location in single mode.
  always @(negedge firstLoadRetx_n)
  begin
    if (fifoReset_n && single)
    begin
      rPtr = 0;
      fill = wPtr;
    end
  end
  // Expansion input pulses hand over the turn to write, then to read.
  always @(negedge expansionIn_n)
  begin
    if (fifoReset_n && !single)
    begin
      xiCount = xiCount + 1;
      wEn = 1'b1;
      rEn = rEn || xiCount >= 2;
    end
  end
  // A write is decided on the falling strobe and stored on the rising one.
  always @(negedge writeStrobe_n)
  begin
    wGo = fifoReset_n && wEn && fill < DEPTH;
    lastW = wGo && !single && wPtr == DEPTH - 1;
  end
  always @(posedge writeStrobe_n)
  begin
    if (wGo)
    begin
      mem[wPtr] = dataIn;
      wPtr = (wPtr + 1) % DEPTH;
      fill = fill + 1;
      wEn = wEn && !lastW;
    end
    wGo = 1'b0;
  end
  always @(posedge wDly) lastW = 1'b0;
  // A read presents the oldest word while its strobe is low.
  always @(negedge readStrobe_n)
  begin
    rGo = fifoReset_n && rEn && fill > 0;
    lastR = rGo && !single && rPtr == DEPTH - 1;
    if (rGo)
      word = mem[rPtr];
    reading = rGo;
  end
  always @(posedge readStrobe_n)
  begin
    if (rGo)
    begin
      rPtr = (rPtr + 1) % DEPTH;
      fill = fill - 1;
      rEn = rEn && !lastR;
    end
    reading = 1'b0;
    rGo = 1'b0;
  end
  always @(posedge rDly) lastR = 1'b0;
endmodule

// ### testbench/fifo_chain_ctrl_tb.sv
/*
  Self-checking bench for the FIFO-chain controller with one device model.
  Assumes the register map and pin timing of the controller's package header.
*/
`timescale 1ns/1ns
`include "fifo_chain_defs.svh"
module fifo_chain_ctrl_tb;
  localparam int DEPTH = 4;
  logic clk = 1'b0, reset_n = 1'b0, regWrite = 1'b0, regRead = 1'b0, rdSeen = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0, lastRd = 32'h0, regRdata;
  logic irq, writeStrobe_n, readStrobe_n, fifoReset_n, firstLoadRetx_n, expansionIn_n;
  logic emptyFlag_n, fullFlag_n, expOut_n;
  logic [8:0] dataToFifo, dataFromFifo;
  logic [31:0] expQ[$], maskQ[$];
  logic [8:0] words[$];
  int miscompares = 0, nTests = 0, xoCount = 0, seed = 34900;
  ////////////////////////////////////////////////////////////////////////////////
  fifo_chain_ctrl #(.DATA_WIDTH(9), .DEVICES(1), .DEPTH(DEPTH)) i_fifo_chain_ctrl (
    .clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .irq(irq),
    .writeStrobe_n(writeStrobe_n), .readStrobe_n(readStrobe_n), .fifoReset_n(fifoReset_n),
    .firstLoadRetx_n(firstLoadRetx_n), .expansionIn_n(expansionIn_n),
    .dataToFifo(dataToFifo), .dataFromFifo(dataFromFifo), .emptyFlag_n(emptyFlag_n),
    .fullFlag_n(fullFlag_n));
  fifo_dev_model #(.DATA_WIDTH(9), .DEPTH(DEPTH)) i_fifo_dev_model (
    .writeStrobe_n(writeStrobe_n), .readStrobe_n(readStrobe_n), .fifoReset_n(fifoReset_n),
    .firstLoadRetx_n(firstLoadRetx_n), .expansionIn_n(expansionIn_n), .dataIn(dataToFifo),
    .dataOut(dataFromFifo), .emptyFlag_n(emptyFlag_n), .fullFlag_n(fullFlag_n),
    .expansionOut_n(expOut_n));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and expansion pulse counting.
  initial forever #25 clk = ~clk;
  always @(negedge expOut_n) xoCount++;
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    nTests++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  // Read data is compared with the oldest expectation the cycle after a read.
  always @(posedge clk)
  begin
    if (rdSeen)
    begin
      lastRd <= regRdata;
      if (expQ.size() == 0)
        check("queue", 32'h1, 32'h0);
      else
        check("regRdata", expQ.pop_front(), regRdata & maskQ.pop_front());
    end
    rdSeen <= regRead;
  end
  task automatic giveVerdict();
    if (miscompares == 0 && nTests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    expQ.push_back(e);
    maskQ.push_back(m);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(posedge clk);
  endtask
  // Issues an order, then polls the busy bit under a bound.
  task automatic op(input logic [7:0] a, input logic [31:0] d);
    int n;
    wr(a, d);
    for (n = 0; n < 40; n++)
    begin
      rd(`REG_STATUS, 32'h0, 32'h0);
      @(posedge clk);
      if (!lastRd[`ST_BUSY_BIT])
        break;
    end
    if (n == 40)
    begin
      miscompares++;
      giveVerdict();
    end
    @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: depth mode lap, refusals, masked interrupt, single mode wrap.
  initial
  begin
    logic [8:0] d;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    rd(`REG_CONTROL, 32'h4, 32'hF);
    rd(`REG_IRQ_STATUS, 32'h0, 32'h7);
    rd(8'h20, 32'h0, 32'hFFFFFFFF);
    wr(`REG_IRQ_ENABLE, 32'h7);
    op(`REG_CONTROL, 32'h5);
    rd(`REG_STATUS, 32'h1, 32'h3);
    repeat (DEPTH)
    begin
      d = 9'($random(seed));
      words.push_back(d);
      op(`REG_WRDATA, {23'h0, d});
    end
    check("xoCount", 32'h1, 32'(xoCount));
    rd(`REG_COUNT, 32'h4, 32'hFFFFFFFF);
    rd(`REG_STATUS, 32'h2, 32'h3);
    op(`REG_WRDATA, 32'h1AB);
    rd(`REG_IRQ_STATUS, 32'h5, 32'h7);
    check("irq", 32'h1, {31'h0, irq});
    wr(`REG_IRQ_CLEAR, 32'h7);
    rd(`REG_IRQ_STATUS, 32'h0, 32'h7);
    check("irq", 32'h0, {31'h0, irq});
    repeat (DEPTH)
    begin
      op(`REG_CONTROL, 32'hC);
      rd(`REG_RDDATA, {23'h0, words.pop_front()}, 32'h1FF);
    end
    check("xoCount", 32'h2, 32'(xoCount));
    rd(`REG_STATUS, 32'h1, 32'h3);
    rd(`REG_COUNT, 32'h0, 32'hFFFFFFFF);
    op(`REG_CONTROL, 32'hC);
    rd(`REG_IRQ_STATUS, 32'h6, 32'h6);
    wr(`REG_IRQ_CLEAR, 32'h7);
    op(`REG_CONTROL, 32'h6);
    rd(`REG_IRQ_STATUS, 32'h4, 32'h4);
    wr(`REG_IRQ_ENABLE, 32'h0);
    op(`REG_CONTROL, 32'h1);
    repeat (3)
    begin
      repeat (3)
      begin
        d = 9'($random(seed));
        words.push_back(d);
        op(`REG_WRDATA, {23'h0, d});
      end
      repeat (3)
      begin
        op(`REG_CONTROL, 32'h8);
        rd(`REG_RDDATA, {23'h0, words.pop_front()}, 32'h1FF);
      end
    end
    check("xoCount", 32'h2, 32'(xoCount));
    // Retransmit in single mode rewinds to the first location, last written word.
    op(`REG_CONTROL, 32'h2);
    op(`REG_CONTROL, 32'h8);
    rd(`REG_RDDATA, {23'h0, d}, 32'h1FF);
    rd(`REG_IRQ_STATUS, 32'h3, 32'h3);
    check("irq", 32'h0, {31'h0, irq});
    giveVerdict();
  end
endmodule
